// ---- design/event_queue.sv ----
`timescale 1ns/10ps
`default_nettype none
module event_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 10,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  output logic [CW-1:0] count,
  output logic full
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  wire empty = (count_reg == '0);
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  assign full = (count_reg == CW'(DEPTH));
  assign count = count_reg;

  // new events beyond capacity are dropped
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      pop_data <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
      // an empty queue reads as zero
      pop_data <= do_pop ? mem[rd_ptr_reg] : '0;
      count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule
`default_nettype wire

// ---- design/i2c_target.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2c_target #(
  parameter logic [6:0] DEV_ADDR = keypad_pkg::I2C_DEV_ADDR
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  reg_access_if.target bus
);
  typedef enum {T_IDLE, T_ADDR, T_PTR, T_DATA, T_READ} tstate_t;
  tstate_t state_reg;
  logic scl_meta, scl_sync, scl_prev, sda_meta, sda_sync, sda_prev;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic ack_reg;
  logic read_reg;

  wire start = scl_sync && scl_prev && sda_prev && !sda_sync;
  wire stop = scl_sync && scl_prev && !sda_prev && sda_sync;
  wire rise = scl_sync && !scl_prev;
  wire fall = !scl_sync && scl_prev;
  wire byte_done = (bit_cnt_reg == 4'h8) && !ack_reg;
  wire addr_hit = (shift_reg[7:1] == DEV_ADDR);

  assign bus.addr = ptr_reg;
  assign bus.wdata = shift_reg;

  always_ff @(posedge clk) begin
    sda_out <= 1'b0; // open drain: the pad only ever pulls low
    {scl_meta, scl_sync, scl_prev} <= {scl_in, scl_meta, scl_sync};
    {sda_meta, sda_sync, sda_prev} <= {sda_in, sda_meta, sda_sync};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= T_IDLE;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      ptr_reg <= '0;
      ack_reg <= 1'b0;
      read_reg <= 1'b0;
      sda_oe_n <= 1'b1;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
    end else begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      if (start || stop) begin
        state_reg <= start ? T_ADDR : T_IDLE;
        bit_cnt_reg <= '0;
        ack_reg <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (rise && state_reg != T_IDLE) begin
        if (ack_reg) begin
          // nack ends a burst; only an ack fetches (and pops) the next byte
          if (state_reg == T_READ && sda_sync) begin
            state_reg <= T_IDLE;
          end else if (state_reg == T_READ) begin
            bus.rd <= 1'b1;
          end
        end else begin
          if (state_reg != T_READ) begin
            shift_reg <= {shift_reg[6:0], sda_sync};
          end
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
      end else if (fall && state_reg != T_IDLE) begin
        if (byte_done) begin
          ack_reg <= 1'b1;
          case (state_reg)
            T_ADDR: begin
              sda_oe_n <= !addr_hit;
              read_reg <= shift_reg[0];
              bus.rd <= addr_hit && shift_reg[0];
              if (!addr_hit) begin
                state_reg <= T_IDLE;
              end
            end
            T_PTR: begin
              ptr_reg <= shift_reg;
              sda_oe_n <= 1'b0;
            end
            T_DATA: begin
              bus.wr <= 1'b1;
              sda_oe_n <= 1'b0;
            end
            T_READ: sda_oe_n <= 1'b1;
            default: sda_oe_n <= 1'b1;
          endcase
        end else if (ack_reg) begin
          ack_reg <= 1'b0;
          bit_cnt_reg <= '0;
          if (state_reg == T_READ || (state_reg == T_ADDR && read_reg)) begin
            state_reg <= T_READ;
            sda_oe_n <= bus.rdata[7];
            shift_reg <= {bus.rdata[6:0], 1'b0};
          end else begin
            state_reg <= (state_reg == T_ADDR) ? T_PTR : T_DATA;
            sda_oe_n <= 1'b1;
          end
        end else if (state_reg == T_READ) begin
          sda_oe_n <= shift_reg[7];
          shift_reg <= {shift_reg[6:0], 1'b0};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/keypad_matrix_scanner.sv ----
// Contract
// - after reset all matrix pins are pulled-up, debounced general inputs.
// - software selects matrix rows and columns; only selected pins scanned.
// - key number is row times ten plus column plus one.
// - idle drives selected columns low, rows stay pulled-up inputs.
// - a selected row low in idle triggers a column scan.
// - key held 25 ms logged with press bit set, in detection order; keys changing in one sweep are logged in key number order.
// - logging sets key event flag; enabled flag drives host interrupt.
// - sample every 25 ms; press needs two consecutive pressed samples.
// - while any key is held, keep sampling every 25 ms.
// - release seen for 25 ms logs key number with press bit clear.
// - release may take 25 to 50 ms to be logged.
// - after last release, scanner returns to idle.
// - reset pin counts only when low at least 50 us.
// - host interrupt is active-low open-drain, released when inactive.
// - unselected pins remain general inputs or outputs.
// - key event flag clears on write one, refused while events remain.
// - events queue ten deep, bit 7 press, low bits key number.
`timescale 1ns/10ps
`default_nettype none
module keypad_matrix_scanner #(
  parameter int SAMPLE_CYCLES = keypad_pkg::SAMPLE_CYCLES,
  parameter int RESET_CYCLES = keypad_pkg::RESET_CYCLES,
  parameter logic [6:0] DEV_ADDR = keypad_pkg::I2C_DEV_ADDR
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [keypad_pkg::NUM_ROWS-1:0] matrix_row_in,
  output logic [keypad_pkg::NUM_ROWS-1:0] matrix_row_out,
  output logic [keypad_pkg::NUM_ROWS-1:0] matrix_row_oe_n,
  output logic [keypad_pkg::NUM_ROWS-1:0] matrix_row_pull_en,
  input wire logic [keypad_pkg::NUM_COLS-1:0] matrix_col_in,
  output logic [keypad_pkg::NUM_COLS-1:0] matrix_col_out,
  output logic [keypad_pkg::NUM_COLS-1:0] matrix_col_oe_n,
  output logic [keypad_pkg::NUM_COLS-1:0] matrix_col_pull_en,
  output logic host_irq_n_out,
  output logic host_irq_n_oe_n
);
  import keypad_pkg::*;

  localparam int TW = $clog2(SAMPLE_CYCLES);
  localparam int RW = $clog2(RESET_CYCLES + 1);
  localparam int QW = $clog2(QUEUE_DEPTH + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(SAMPLE_CYCLES - 1);
  localparam logic [RW-1:0] RESET_LAST = RW'(RESET_CYCLES);
  localparam logic [2:0] SETTLE_LAST = 3'(SETTLE_CYCLES - 1);
  localparam logic [3:0] COL_LAST = 4'(NUM_COLS - 1);
  localparam logic [6:0] KEY_LAST = 7'(NUM_KEYS - 1);

  typedef enum {S_IDLE, S_DRIVE, S_LOG, S_WAIT} scan_state_t;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] key_number(input logic [6:0] idx);
    key_number = {1'b0, idx + 7'h01};
  endfunction

  function automatic logic [NUM_KEYS-1:0] capture_col(
      input logic [NUM_KEYS-1:0] keys, input logic [3:0] col,
      input logic [NUM_ROWS-1:0] pressed);
    logic [NUM_KEYS-1:0] res;
    res = keys;
    for (int r = 0; r < NUM_ROWS; r++) begin
      res[r * NUM_COLS + int'(col)] = pressed[r];
    end
    capture_col = res;
  endfunction

  function automatic logic bank_hit(input logic [7:0] a, input logic [7:0] b);
    bank_hit = (a >= b) && (a < b + 8'(GPIO_BANKS));
  endfunction

  // ------------------------------------------------------------
  // reset pin qualification
  // ------------------------------------------------------------
  logic rpin_meta, rpin_sync;
  logic [RW-1:0] rpin_cnt_reg;
  logic pin_rst_reg;
  wire core_rst = rst || pin_rst_reg;

  always_ff @(posedge clk) begin
    rpin_meta <= reset_pin_n;
    rpin_sync <= rpin_meta;
  end

  // short low pulses never reach the threshold and are ignored
  always_ff @(posedge clk) begin
    if (rst || rpin_sync) begin
      rpin_cnt_reg <= '0;
      pin_rst_reg <= 1'b0;
    end else begin
      if (rpin_cnt_reg != RESET_LAST) begin
        rpin_cnt_reg <= rpin_cnt_reg + 1'b1;
      end
      pin_rst_reg <= (rpin_cnt_reg == RESET_LAST);
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers: rows low, columns high
  // ------------------------------------------------------------
  logic [NUM_PINS-1:0] pin_meta, pin_sync, pin_prev_reg, pin_deb_reg;
  always_ff @(posedge clk) begin
    pin_meta <= {matrix_col_in, matrix_row_in};
    pin_sync <= pin_meta;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg_access_if bus ();
  logic irq_en_reg, ke_flag_reg;
  logic [NUM_ROWS-1:0] sel_rows_reg;
  logic [NUM_COLS-1:0] sel_cols_reg;
  logic [23:0] gpio_out_reg, gpio_dir_reg;
  logic [7:0] rdata_reg;
  logic event_rd_reg;
  logic [EVENT_WIDTH-1:0] queue_data;
  logic [QW-1:0] queue_count;
  logic queue_full;
  logic push;
  logic [EVENT_WIDTH-1:0] push_data;

  wire wr_status = bus.wr && bus.addr == REG_IRQ_STATUS;
  wire clear_req = wr_status && bus.wdata[KE_FLAG_BIT];
  wire event_addr = bus.addr >= REG_EVENT_FIRST
      && bus.addr <= REG_EVENT_LAST;
  wire pop = bus.rd && event_addr;
  wire logged = push && !queue_full;
  wire [23:0] gpio_in_word = {6'h00, pin_deb_reg};
  wire [4:0] in_sel = 5'(bus.addr - REG_GPIO_IN_BASE) << 3;
  wire [4:0] out_sel = 5'(bus.addr - REG_GPIO_OUT_BASE) << 3;
  wire [4:0] dir_sel = 5'(bus.addr - REG_GPIO_DIR_BASE) << 3;
  wire hit_in = bank_hit(bus.addr, REG_GPIO_IN_BASE);
  wire hit_out = bank_hit(bus.addr, REG_GPIO_OUT_BASE);
  wire hit_dir = bank_hit(bus.addr, REG_GPIO_DIR_BASE);

  logic [7:0] read_mux;
  always_comb begin
    read_mux = 8'h00;
    case (bus.addr)
      REG_IRQ_ENABLE: read_mux[KEY_EVENT_IRQ_ENABLE_BIT] = irq_en_reg;
      REG_IRQ_STATUS: read_mux[KE_FLAG_BIT] = ke_flag_reg;
      REG_EVENT_COUNT: read_mux = 8'(queue_count);
      REG_SEL_ROWS: read_mux = sel_rows_reg;
      REG_SEL_COLS_LO: read_mux = sel_cols_reg[7:0];
      REG_SEL_COLS_HI: read_mux = {6'h00, sel_cols_reg[9:8]};
      default: begin
        if (hit_in) begin
          read_mux = gpio_in_word[in_sel +: 8];
        end else if (hit_out) begin
          read_mux = gpio_out_reg[out_sel +: 8];
        end else if (hit_dir) begin
          read_mux = gpio_dir_reg[dir_sel +: 8];
        end
      end
    endcase
  end
  assign bus.rdata = rdata_reg;

  always_ff @(posedge clk) begin
    if (core_rst) begin
      irq_en_reg <= 1'b0;
      sel_rows_reg <= SEL_RESET;
      sel_cols_reg <= {2'b00, SEL_RESET};
      gpio_out_reg <= GPIO_RESET;
      gpio_dir_reg <= GPIO_RESET;
      rdata_reg <= 8'h00;
      event_rd_reg <= 1'b0;
    end else begin
      event_rd_reg <= pop;
      // queue data shows one cycle after the pop
      if (event_rd_reg) begin
        rdata_reg <= queue_data;
      end else if (bus.rd) begin
        rdata_reg <= read_mux;
      end
      if (bus.wr) begin
        case (bus.addr)
          REG_IRQ_ENABLE: irq_en_reg <= bus.wdata[KEY_EVENT_IRQ_ENABLE_BIT];
          REG_SEL_ROWS: sel_rows_reg <= bus.wdata;
          REG_SEL_COLS_LO: sel_cols_reg[7:0] <= bus.wdata;
          REG_SEL_COLS_HI: sel_cols_reg[9:8] <= bus.wdata[1:0];
          default: begin
            if (hit_out) begin
              gpio_out_reg[out_sel +: 8] <= bus.wdata;
            end
            if (hit_dir) begin
              gpio_dir_reg[dir_sel +: 8] <= bus.wdata;
            end
          end
        endcase
      end
    end
  end

  // event flag: a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (core_rst) begin
      ke_flag_reg <= 1'b0;
    end else if (logged) begin
      ke_flag_reg <= 1'b1;
    end else if (clear_req && queue_count == '0) begin
      ke_flag_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // sample tick and general input debounce
  // ------------------------------------------------------------
  scan_state_t state_reg;
  logic [TW-1:0] tick_cnt_reg;
  wire [NUM_ROWS-1:0] rows_low = ~pin_sync[NUM_ROWS-1:0] & sel_rows_reg;
  wire trigger = state_reg == S_IDLE && |rows_low && |sel_cols_reg;
  wire tick = tick_cnt_reg == TICK_LAST;

  always_ff @(posedge clk) begin
    if (core_rst || trigger) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
    end
  end

  // an input bit updates only when two ticks agree
  always_ff @(posedge clk) begin
    if (core_rst) begin
      pin_prev_reg <= '1;
      pin_deb_reg <= '1;
    end else if (tick) begin
      pin_prev_reg <= pin_sync;
      pin_deb_reg <= (pin_sync & ~(pin_sync ^ pin_prev_reg))
          | (pin_deb_reg & (pin_sync ^ pin_prev_reg));
    end
  end

  // ------------------------------------------------------------
  // scanner
  // ------------------------------------------------------------
  logic [3:0] col_reg;
  logic [2:0] settle_reg;
  logic [6:0] key_reg;
  logic [NUM_KEYS-1:0] sample_reg, prev_reg, stable_reg;
  wire col_on = sel_cols_reg[col_reg];
  wire [NUM_ROWS-1:0] col_rows = col_on ? rows_low : '0;
  wire key_now = sample_reg[key_reg];
  wire key_change = key_now == prev_reg[key_reg]
      && key_now != stable_reg[key_reg];
  wire all_clear = ~|sample_reg && ~|prev_reg;

  assign push = state_reg == S_LOG && key_change;
  assign push_data = key_number(key_reg)
      | {key_now, 7'h00};

  always_ff @(posedge clk) begin
    if (core_rst) begin
      state_reg <= S_IDLE;
      col_reg <= '0;
      settle_reg <= '0;
      key_reg <= '0;
      sample_reg <= '0;
      prev_reg <= '0;
      stable_reg <= '0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          col_reg <= '0;
          settle_reg <= '0;
          if (trigger) begin
            state_reg <= S_DRIVE;
          end
        end
        S_DRIVE: begin
          // wait for pin register plus synchroniser to settle
          settle_reg <= settle_reg + 3'h1;
          if (settle_reg == SETTLE_LAST) begin
            settle_reg <= '0;
            sample_reg <= capture_col(sample_reg, col_reg, col_rows);
            if (col_reg == COL_LAST) begin
              key_reg <= '0;
              state_reg <= S_LOG;
            end else begin
              col_reg <= col_reg + 4'h1;
            end
          end
        end
        S_LOG: begin
          // keys logged in index order within one sweep
          if (key_change) begin
            stable_reg[key_reg] <= key_now;
          end
          key_reg <= key_reg + 7'h01;
          if (key_reg == KEY_LAST) begin
            prev_reg <= sample_reg;
            state_reg <= all_clear ? S_IDLE : S_WAIT;
          end
        end
        S_WAIT: begin
          col_reg <= '0;
          if (tick) begin
            state_reg <= S_DRIVE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  logic [NUM_PINS-1:0] drive_low, pin_oe_n_next, pin_out_next;
  always_comb begin
    for (int c = 0; c < NUM_COLS; c++) begin
      drive_low[NUM_ROWS + c] = sel_cols_reg[c]
          && (state_reg == S_IDLE
          || (state_reg == S_DRIVE && int'(col_reg) == c));
    end
    drive_low[NUM_ROWS-1:0] = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (p < NUM_ROWS ? sel_rows_reg[p] : sel_cols_reg[p - NUM_ROWS]) begin
        pin_oe_n_next[p] = !drive_low[p];
        pin_out_next[p] = 1'b0;
      end else begin
        pin_oe_n_next[p] = !gpio_dir_reg[p];
        pin_out_next[p] = gpio_out_reg[p];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      {matrix_col_oe_n, matrix_row_oe_n} <= '1;
      {matrix_col_out, matrix_row_out} <= '0;
      {matrix_col_pull_en, matrix_row_pull_en} <= '1;
      host_irq_n_out <= 1'b0;
      host_irq_n_oe_n <= 1'b1;
    end else begin
      {matrix_col_oe_n, matrix_row_oe_n} <= pin_oe_n_next;
      {matrix_col_out, matrix_row_out} <= pin_out_next;
      {matrix_col_pull_en, matrix_row_pull_en} <= pin_oe_n_next;
      host_irq_n_out <= 1'b0;
      host_irq_n_oe_n <= !(ke_flag_reg && irq_en_reg);
    end
  end

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  event_queue #(
    .WIDTH(EVENT_WIDTH),
    .DEPTH(QUEUE_DEPTH)
  ) queue (
    .clk(clk),
    .rst(core_rst),
    .push(push),
    .push_data(push_data),
    .pop(pop),
    .pop_data(queue_data),
    .count(queue_count),
    .full(queue_full)
  );

  i2c_target #(
    .DEV_ADDR(DEV_ADDR)
  ) target (
    .clk(clk),
    .rst(core_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .bus(bus.target)
  );
endmodule
`default_nettype wire

// ---- design/keypad_pkg.sv ----
package keypad_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h01;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h02;
  localparam logic [7:0] REG_EVENT_COUNT = 8'h03;
  localparam logic [7:0] REG_EVENT_FIRST = 8'h04;
  localparam logic [7:0] REG_EVENT_LAST = 8'h0D;
  localparam logic [7:0] REG_GPIO_IN_BASE = 8'h14;
  localparam logic [7:0] REG_GPIO_OUT_BASE = 8'h17;
  localparam logic [7:0] REG_SEL_ROWS = 8'h1D;
  localparam logic [7:0] REG_SEL_COLS_LO = 8'h1E;
  localparam logic [7:0] REG_SEL_COLS_HI = 8'h1F;
  localparam logic [7:0] REG_GPIO_DIR_BASE = 8'h20;
  localparam int GPIO_BANKS = 3;

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int KEY_EVENT_IRQ_ENABLE_BIT = 0;
  localparam int KE_FLAG_BIT = 0;
  localparam int PRESS_BIT = 7;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [23:0] GPIO_RESET = 24'h000000;
  localparam logic [23:0] PIN_MASK = 24'h03FFFF;
  localparam logic [6:0] I2C_DEV_ADDR = 7'h34;

  // ------------------------------------------------------------
  // matrix geometry
  // ------------------------------------------------------------
  localparam int NUM_ROWS = 8;
  localparam int NUM_COLS = 10;
  localparam int NUM_KEYS = NUM_ROWS * NUM_COLS;
  localparam int NUM_PINS = NUM_ROWS + NUM_COLS;
  localparam int QUEUE_DEPTH = 10;
  localparam int EVENT_WIDTH = 8;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SAMPLE_PERIOD_MS = 25;
  localparam int RESET_MIN_US = 50;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_MS * (CLK_HZ / 1000);
  localparam int RESET_CYCLES = RESET_MIN_US * (CLK_HZ / 1_000_000);
  localparam int SETTLE_CYCLES = 4;

endpackage

// ---- design/reg_access_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface reg_access_if;
  logic [7:0] addr;
  logic wr;
  logic [7:0] wdata;
  logic rd;
  logic [7:0] rdata;
  modport target (output addr, output wr, output wdata, output rd,
                  input rdata);
  modport regfile (input addr, input wr, input wdata, input rd,
                   output rdata);
endinterface
`default_nettype wire

// ---- verif/keypad_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module keypad_monitor #(
  parameter int SAMPLE_CYCLES = 400,
  parameter int RESET_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic scl_in,
  input wire logic [keypad_pkg::NUM_ROWS-1:0] matrix_row_in,
  input wire logic [keypad_pkg::NUM_ROWS-1:0] matrix_row_oe_n,
  input wire logic [keypad_pkg::NUM_ROWS-1:0] matrix_row_pull_en,
  input wire logic [keypad_pkg::NUM_COLS-1:0] matrix_col_oe_n,
  input wire logic [keypad_pkg::NUM_COLS-1:0] matrix_col_pull_en,
  input wire logic host_irq_n_out,
  input wire logic host_irq_n_oe_n
);
  import keypad_pkg::*;
  logic scl_reg;
  int quiet_reg, low_reg, pin_reg;
  // host quiet time and time since any row was seen low
  always_ff @(posedge clk) begin
    scl_reg <= scl_in;
    quiet_reg <= (rst || scl_in != scl_reg) ? 0 : quiet_reg + 1;
    low_reg <= (rst || !(&matrix_row_in)) ? 0 : low_reg + 1;
    pin_reg <= reset_pin_n ? 0 : pin_reg + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_od;
    host_irq_n_out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("irq drives high");
  property p_dflt;
    disable iff (1'b0) rst |=> &matrix_row_oe_n && &matrix_col_oe_n
      && &matrix_col_pull_en && host_irq_n_oe_n;
  endproperty
  a_dflt: assert property (p_dflt) else $error("reset pins");
  property p_rpull;
    matrix_row_pull_en == matrix_row_oe_n;
  endproperty
  a_rpull: assert property (p_rpull) else $error("row pull");
  property p_cpull;
    matrix_col_pull_en == matrix_col_oe_n;
  endproperty
  a_cpull: assert property (p_cpull) else $error("col pull");
  property p_pin;
    pin_reg >= RESET_CYCLES + 8 |-> &matrix_col_oe_n && host_irq_n_oe_n;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset");
  // guards keep a pin reset from looking like a spurious clear
  property p_hold;
    quiet_reg >= 16 && reset_pin_n && $past(reset_pin_n, 8)
      && !$past(host_irq_n_oe_n) |-> !host_irq_n_oe_n;
  endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_cause;
    $fell(host_irq_n_oe_n) |-> low_reg < 3 * SAMPLE_CYCLES;
  endproperty
  a_cause: assert property (p_cause) else $error("irq no key");
  property p_idle;
    low_reg > 3 * SAMPLE_CYCLES && quiet_reg >= 16 && reset_pin_n
      && $past(reset_pin_n, 8) |-> $stable(matrix_col_oe_n);
  endproperty
  a_idle: assert property (p_idle) else $error("idle scan");
  c_irq: cover property ($fell(host_irq_n_oe_n));
  c_clr: cover property ($rose(host_irq_n_oe_n));
  c_pin: cover property (pin_reg == RESET_CYCLES + 8);
endmodule
bind keypad_matrix_scanner keypad_monitor #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES),
  .RESET_CYCLES(RESET_CYCLES)
) u_keypad_monitor (.clk, .rst, .reset_pin_n, .scl_in, .matrix_row_in,
  .matrix_row_oe_n, .matrix_row_pull_en, .matrix_col_oe_n,
  .matrix_col_pull_en, .host_irq_n_out, .host_irq_n_oe_n);
`default_nettype wire

// ---- verif/keypad_switch_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module keypad_switch_model (
  input wire logic key_on,
  input wire logic [2:0] key_row,
  input wire logic [3:0] key_col,
  input wire logic [keypad_pkg::NUM_ROWS-1:0] row_out,
  input wire logic [keypad_pkg::NUM_ROWS-1:0] row_oe_n,
  input wire logic [keypad_pkg::NUM_COLS-1:0] col_out,
  input wire logic [keypad_pkg::NUM_COLS-1:0] col_oe_n,
  output logic [keypad_pkg::NUM_ROWS-1:0] row_in,
  output logic [keypad_pkg::NUM_COLS-1:0] col_in
);
  import keypad_pkg::*;
  logic [7:0] hit;
  // board pull-ups: a line nobody drives reads high
  assign hit = {7'h00, key_on && !col_oe_n[key_col] && !col_out[key_col]};
  assign row_in = (~row_oe_n & row_out) | (row_oe_n & ~(hit << key_row));
  assign col_in = col_oe_n | col_out;
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import keypad_pkg::*;
  localparam int SP = 400;
  logic clk = 0, rst = 1, pin_n = 1, scl = 1, sda = 1, key_on = 0, ack;
  logic [2:0] key_row = 0;
  logic [3:0] key_col = 0;
  logic sda_o, sda_oe_n, irq_o, irq_oe_n, sda_line;
  logic [7:0] rd, ri, ro, roe_n, rpu;
  logic [9:0] ci, co, coe_n, cpu;
  int mismatches = 0, compares = 0, cycles = 0, n;
  assign sda_line = sda && (sda_oe_n || sda_o);
  always #12.5 clk = ~clk;
  keypad_matrix_scanner #(.SAMPLE_CYCLES(SP), .RESET_CYCLES(20))
    u_keypad_matrix_scanner (.clk(clk), .rst(rst), .reset_pin_n(pin_n),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o), .sda_oe_n(sda_oe_n),
    .matrix_row_in(ri), .matrix_row_out(ro), .matrix_row_oe_n(roe_n),
    .matrix_row_pull_en(rpu), .matrix_col_in(ci), .matrix_col_out(co),
    .matrix_col_oe_n(coe_n), .matrix_col_pull_en(cpu),
    .host_irq_n_out(irq_o), .host_irq_n_oe_n(irq_oe_n));
  keypad_switch_model u_keypad_switch_model (.key_on(key_on),
    .key_row(key_row), .key_col(key_col), .row_out(ro), .row_oe_n(roe_n),
    .col_out(co), .col_oe_n(coe_n), .row_in(ri), .col_in(ci));
  task automatic chk(input logic [9:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic w(input int k);
    repeat (k) @(negedge clk);
  endtask
  // sda moves two cycles after scl falls, never with it
  task automatic bt(input logic b);
    w(2);
    sda = b;
    w(10);
    scl = 1;
    w(5);
    ack = sda_line;
    w(5);
    scl = 0;
  endtask
  task automatic start();
    w(2);
    sda = 1;
    w(10);
    scl = 1;
    w(10);
    sda = 0;
    w(10);
    scl = 0;
  endtask
  task automatic stop();
    w(2);
    sda = 0;
    w(10);
    scl = 1;
    w(10);
    sda = 1;
    w(10);
  endtask
  task automatic wb(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bt(b[i]);
    bt(1'b1);
    chk(ack, 1'b0, "no ack");
  endtask
  task automatic wr(input logic [7:0] a, d);
    start();
    wb({I2C_DEV_ADDR, 1'b0});
    wb(a);
    wb(d);
    stop();
  endtask
  task automatic rr(input logic [7:0] a);
    start();
    wb({I2C_DEV_ADDR, 1'b0});
    wb(a);
    start();
    wb({I2C_DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bt(1'b1);
      rd[i] = ack;
    end
    bt(1'b1);
    stop();
  endtask
  task automatic wait_irq(input logic lvl);
    n = 0;
    while (irq_oe_n !== lvl && n < 3 * SP) begin
      w(1);
      n++;
    end
  endtask
  task automatic t_key(input logic [2:0] r, input logic [3:0] c,
      input logic [6:0] num);
    key_row = r;
    key_col = c;
    key_on = 1;
    wait_irq(1'b0);
    chk(n >= SP && n <= SP + 200, 1, "press time");
    wr(REG_IRQ_STATUS, 8'h01);
    chk(irq_oe_n, 1'b0, "cleared early");
    rr(REG_EVENT_FIRST);
    chk(rd, {1'b1, num}, "press code");
    wr(REG_IRQ_STATUS, 8'h01);
    chk(irq_oe_n, 1'b1, "no clear");
    key_on = 0;
    wait_irq(1'b0);
    chk(n >= SP && n <= 2 * SP + 150, 1, "release time");
    rr(REG_EVENT_LAST);
    chk(rd, {1'b0, num}, "release code");
    wr(REG_IRQ_STATUS, 8'h01);
    w(2 * SP);
    chk(coe_n, 10'h1FA, "not idle");
  endtask
  task automatic t_none(input logic [3:0] c, input int hold);
    key_row = 0;
    key_col = c;
    key_on = 1;
    w(hold);
    key_on = 0;
    w(3 * SP);
    rr(REG_EVENT_COUNT);
    chk(rd, 8'h00, "false event");
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    w(4);
    rst = 0;
    w(4);
    chk(coe_n & cpu, 10'h3FF, "pins after reset");
    rr(8'h30);
    chk(rd, 8'h00, "unmapped");
    wr(REG_SEL_ROWS, 8'h81);
    wr(REG_SEL_COLS_LO, 8'h05);
    wr(REG_SEL_COLS_HI, 8'h02);
    wr(REG_IRQ_ENABLE, 8'h01);
    rr(REG_SEL_COLS_LO);
    chk(rd, 8'h05, "select readback");
    chk(coe_n | co, 10'h1FA, "idle drive");
    chk(roe_n, 8'hFF, "rows driven");
    t_key(3'd0, 4'd0, 7'd1);
    t_key(3'd7, 4'd9, 7'd80);
    t_none(4'd0, 30);
    t_none(4'd1, 2 * SP);
    pin_n = 0;
    w(10);
    pin_n = 1;
    rr(REG_SEL_ROWS);
    chk(rd, 8'h81, "short pulse reset");
    pin_n = 0;
    w(40);
    pin_n = 1;
    rr(REG_SEL_ROWS);
    chk(rd, 8'h00, "no pin reset");
    give_verdict();
  end
endmodule
`default_nettype wire
